// File: hdl/aesm_pkg.sv
/*
  Constants, codes and carrier types for the audio element speaker mapper.
  Assumes a single 50 MHz system clock and synchronous active-high reset.
*/
package aesm_pkg;

  localparam int unsigned NUM_RATES = 12;
  localparam logic [16:0] RATE_TABLE [NUM_RATES] = '{
    17'h17700, 17'h15888, 17'h0fa00, 17'h0bb80, 17'h0ac44, 17'h07d00,
    17'h05dc0, 17'h05622, 17'h03e80, 17'h02ee0, 17'h02b11, 17'h01f40};
  localparam logic [5:0]  MAX_CHANNELS = 6'h30;
  localparam int unsigned NUM_BANDS    = 4;
  localparam logic [1:0]  BAND_DIV_SHIFT = 2'h3;

  localparam logic [10:0] LINES_SHORT = 11'h080;
  localparam logic [10:0] LINES_LONG  = 11'h400;

  // layout codes
  localparam logic [2:0] LAY_1   = 3'h1;
  localparam logic [2:0] LAY_2   = 3'h2;
  localparam logic [2:0] LAY_3   = 3'h3;
  localparam logic [2:0] LAY_4   = 3'h4;
  localparam logic [2:0] LAY_5   = 3'h5;
  localparam logic [2:0] LAY_5P1 = 3'h6;
  localparam logic [2:0] LAY_7P1 = 3'h7;

  // element kinds
  localparam logic [1:0] EL_SINGLE = 2'h0;
  localparam logic [1:0] EL_PAIR   = 2'h1;
  localparam logic [1:0] EL_LFE    = 2'h2;

  // speaker codes
  localparam logic [3:0] SPK_NONE = 4'h0;
  localparam logic [3:0] SPK_CF   = 4'h1;
  localparam logic [3:0] SPK_LF   = 4'h2;
  localparam logic [3:0] SPK_RF   = 4'h3;
  localparam logic [3:0] SPK_LCF  = 4'h4;
  localparam logic [3:0] SPK_RCF  = 4'h5;
  localparam logic [3:0] SPK_LOF  = 4'h6;
  localparam logic [3:0] SPK_ROF  = 4'h7;
  localparam logic [3:0] SPK_RSUR = 4'h8;
  localparam logic [3:0] SPK_LS   = 4'h9;
  localparam logic [3:0] SPK_RS   = 4'ha;
  localparam logic [3:0] SPK_LFE  = 4'hb;

  // variable-length code kinds
  localparam logic [1:0] VLC_SPECTRAL = 2'h0;
  localparam logic [1:0] VLC_SF_DELTA = 2'h1;
  localparam logic [1:0] VLC_INTENS   = 2'h2;
  localparam logic [3:0] VLC_MAX_PREFIX = 4'hf;

  // inverse quantizer: magnitude^(4/3) in Q4, 2^(k/4) in Q8
  localparam logic [9:0] IQ_POW_TABLE [16] = '{
    10'h000, 10'h010, 10'h028, 10'h045, 10'h066, 10'h089, 10'h0ae, 10'h0d6,
    10'h100, 10'h12c, 10'h159, 10'h187, 10'h1b8, 10'h1e9, 10'h21c, 10'h250};
  localparam logic [8:0] IQ_GAIN_TABLE [4] = '{9'h100, 9'h130, 9'h16a, 9'h1af};
  localparam int unsigned IQ_FRAC_BITS = 12;
  localparam int unsigned COEF_FRAC_BITS = 8;

  typedef struct packed {
    logic signed [15:0] first;   // mid when mid/side is on, else left
    logic signed [15:0] second;  // side when mid/side is on, else right
    logic        [5:0]  sf;
    logic        [1:0]  band;
  } aesm_spec_t;

  typedef struct packed {
    logic signed [31:0] centre;
    logic signed [31:0] surr_l;
    logic signed [31:0] surr_r;
  } aesm_dmx_t;

  typedef struct packed {
    logic [1:0] kind;
    logic [3:0] spk0;
    logic [3:0] spk1;
    logic       last;
  } aesm_map_t;

endpackage

// File: hdl/aesm_inv_quant.sv
/*
  One-cycle inverse quantizer for a single quantized spectral value.
  Saturates magnitudes above 15 to 15 itself rather than relying on the entropy stage.
*/
`timescale 1ns/1ps
`default_nettype none
module aesm_inv_quant (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic signed [15:0] q_in,
  input  wire logic        [5:0]  sf,
  output logic signed      [31:0] value
);
  logic        [3:0]  mag;
  logic        [18:0] prod;
  logic        [31:0] scaled;
  logic signed [31:0] next_value;

  always_comb begin
    // clip keeps the table small; larger magnitudes saturate
    if (q_in < 0)
      mag = (q_in < -16'sd15) ? 4'hf : 4'(-q_in);
    else
      mag = (q_in > 16'sd15) ? 4'hf : q_in[3:0];
    prod   = 19'(aesm_pkg::IQ_POW_TABLE[mag] * aesm_pkg::IQ_GAIN_TABLE[sf[1:0]]);
    // every four scale increments double the gain: 6 dB / 4 = 1.5 dB
    // shift in a wide word so large scale factors do not wrap before the cut
    scaled = 32'((51'(prod) << sf[5:2]) >> aesm_pkg::IQ_FRAC_BITS);
    next_value = (q_in < 0) ? -$signed(scaled) : $signed(scaled);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      value <= 32'sh0;
    else
      value <= next_value;
  end
endmodule
`default_nettype wire

// File: hdl/aesm_top.sv
/*
  Decoder configuration check, element-to-speaker mapping, block and window
  selection, band selection, variable-length decoding and the spectral path
  (inverse quantizer, mid/side, down-mix, mute).
  Assumes the parser presents inputs synchronous to clk_sys, one word a cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module aesm_top (
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic                cfg_valid,
  input  wire logic         [16:0] cfg_rate_hz,
  input  wire logic         [2:0]  cfg_layout,
  input  wire logic         [5:0]  cfg_channels,
  input  wire logic                elem_valid,
  input  wire logic         [1:0]  elem_kind,
  output aesm_pkg::aesm_map_t      map_out,
  output logic                     map_valid,
  input  wire logic                blk_valid,
  input  wire logic                blk_short,
  input  wire logic                blk_win_shape,
  output logic              [10:0] blk_lines,
  output logic                     win_shape,
  input  wire logic         [3:0]  band_scalable_profile,
  output logic              [16:0] bandwidth_hz,
  input  wire logic                bit_valid,
  input  wire logic                bit_in,
  input  wire logic         [1:0]  vlc_kind,
  output logic                     vlc_valid,
  output logic              [1:0]  vlc_kind_out,
  output logic signed       [15:0] vlc_value,
  output logic                     vlc_err,
  input  wire logic                spec_valid,
  input  wire aesm_pkg::aesm_spec_t spec_in,
  input  wire aesm_pkg::aesm_dmx_t spec_dmx,
  input  wire logic                ms_en,
  input  wire logic                dmx_en,
  input  wire logic         [7:0]  dmx_coef,
  output logic                     out_valid,
  output logic signed       [31:0] out_left,
  output logic signed       [31:0] out_right,
  output logic                     cfg_err
);
  // ---- configuration check and mute ----
  logic        rate_ok;
  logic        next_cfg_err;
  logic [2:0]  layout;
  logic [2:0]  next_layout;
  logic [16:0] rate;
  logic [16:0] next_rate;
  logic        map_err;

  always_comb begin
    rate_ok = 1'b0;
    for (int i = 0; i < aesm_pkg::NUM_RATES; i++)
      if (cfg_rate_hz == aesm_pkg::RATE_TABLE[i])
        rate_ok = 1'b1;
    next_cfg_err = cfg_err | map_err;
    next_layout  = layout;
    next_rate    = rate;
    if (cfg_valid) begin
      next_layout = cfg_layout;
      next_rate   = cfg_rate_hz;
      // channel ceiling; bad stream flags error
      next_cfg_err = !rate_ok || cfg_channels > aesm_pkg::MAX_CHANNELS ||
                     cfg_channels == 6'h00 || cfg_layout == 3'h0 || map_err;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_err <= 1'b1;
      layout  <= 3'h0;
      rate    <= 17'h0;
    end else begin
      cfg_err <= next_cfg_err;
      layout  <= next_layout;
      rate    <= next_rate;
    end
  end

  // ---- element to speaker mapping ----
  function automatic aesm_pkg::aesm_map_t map_expect(input logic [2:0] lay, input logic [2:0] idx);
    aesm_pkg::aesm_map_t m;
    m = '{kind: aesm_pkg::EL_SINGLE, spk0: aesm_pkg::SPK_NONE, spk1: aesm_pkg::SPK_NONE, last: 1'b1};
    unique case ({lay, idx})
      {aesm_pkg::LAY_1, 3'h0}: m = '{aesm_pkg::EL_SINGLE, aesm_pkg::SPK_CF, aesm_pkg::SPK_NONE, 1'b1};
      {aesm_pkg::LAY_2, 3'h0}: m = '{aesm_pkg::EL_PAIR, aesm_pkg::SPK_LF, aesm_pkg::SPK_RF, 1'b1};
      {aesm_pkg::LAY_3, 3'h0},
      {aesm_pkg::LAY_4, 3'h0},
      {aesm_pkg::LAY_5, 3'h0},
      {aesm_pkg::LAY_5P1, 3'h0},
      {aesm_pkg::LAY_7P1, 3'h0}: m = '{aesm_pkg::EL_SINGLE, aesm_pkg::SPK_CF, aesm_pkg::SPK_NONE, 1'b0};
      {aesm_pkg::LAY_3, 3'h1}: m = '{aesm_pkg::EL_PAIR, aesm_pkg::SPK_LF, aesm_pkg::SPK_RF, 1'b1};
      {aesm_pkg::LAY_4, 3'h1},
      {aesm_pkg::LAY_5, 3'h1},
      {aesm_pkg::LAY_5P1, 3'h1}: m = '{aesm_pkg::EL_PAIR, aesm_pkg::SPK_LF, aesm_pkg::SPK_RF, 1'b0};
      {aesm_pkg::LAY_4, 3'h2}: m = '{aesm_pkg::EL_SINGLE, aesm_pkg::SPK_RSUR, aesm_pkg::SPK_NONE, 1'b1};
      {aesm_pkg::LAY_5, 3'h2}: m = '{aesm_pkg::EL_PAIR, aesm_pkg::SPK_LS, aesm_pkg::SPK_RS, 1'b1};
      {aesm_pkg::LAY_5P1, 3'h2}: m = '{aesm_pkg::EL_PAIR, aesm_pkg::SPK_LS, aesm_pkg::SPK_RS, 1'b0};
      {aesm_pkg::LAY_5P1, 3'h3}: m = '{aesm_pkg::EL_LFE, aesm_pkg::SPK_LFE, aesm_pkg::SPK_NONE, 1'b1};
      {aesm_pkg::LAY_7P1, 3'h1}: m = '{aesm_pkg::EL_PAIR, aesm_pkg::SPK_LCF, aesm_pkg::SPK_RCF, 1'b0};
      {aesm_pkg::LAY_7P1, 3'h2}: m = '{aesm_pkg::EL_PAIR, aesm_pkg::SPK_LOF, aesm_pkg::SPK_ROF, 1'b0};
      {aesm_pkg::LAY_7P1, 3'h3}: m = '{aesm_pkg::EL_PAIR, aesm_pkg::SPK_LS, aesm_pkg::SPK_RS, 1'b0};
      {aesm_pkg::LAY_7P1, 3'h4}: m = '{aesm_pkg::EL_LFE, aesm_pkg::SPK_LFE, aesm_pkg::SPK_NONE, 1'b1};
      default: m.kind = 2'h3;  // no element expected here
    endcase
    return m;
  endfunction

  aesm_pkg::aesm_map_t expect_now;
  aesm_pkg::aesm_map_t next_map;
  logic [2:0]          elem_idx;
  logic [2:0]          next_elem_idx;
  logic                done;
  logic                next_done;

  always_comb begin
    expect_now    = map_expect(layout, elem_idx);
    next_map      = map_out;
    next_elem_idx = elem_idx;
    next_done     = done;
    map_err       = 1'b0;
    if (cfg_valid) begin
      next_elem_idx = 3'h0;
      next_done     = 1'b0;
    end else if (elem_valid) begin
      if (done || expect_now.kind != elem_kind) begin
        map_err  = 1'b1;
        next_map = '{kind: elem_kind, spk0: aesm_pkg::SPK_NONE, spk1: aesm_pkg::SPK_NONE, last: 1'b0};
      end else begin
        next_map      = expect_now;
        next_elem_idx = elem_idx + 3'h1;
        next_done     = expect_now.last;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      map_out   <= '0;
      map_valid <= 1'b0;
      elem_idx  <= 3'h0;
      done      <= 1'b0;
    end else begin
      map_out   <= next_map;
      map_valid <= elem_valid && !cfg_valid;
      elem_idx  <= next_elem_idx;
      done      <= next_done;
    end
  end

  // ---- block length, window, bands ----
  logic [10:0] next_blk_lines;
  logic        next_win_shape;
  logic [16:0] next_bandwidth;
  logic [2:0]  top_band;

  always_comb begin
    next_blk_lines = blk_lines;
    next_win_shape = win_shape;
    if (blk_valid) begin
      next_blk_lines = blk_short ? aesm_pkg::LINES_SHORT : aesm_pkg::LINES_LONG;
      next_win_shape = blk_win_shape;
    end
    top_band = 3'h0;
    for (int b = 0; b < aesm_pkg::NUM_BANDS; b++)
      if (band_scalable_profile[b])
        top_band = 3'(b + 1);
    // each band spans rate/8, so 48 kHz lowest band gives 6 kHz
    next_bandwidth = 17'((rate >> aesm_pkg::BAND_DIV_SHIFT) * top_band);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      blk_lines    <= aesm_pkg::LINES_LONG;
      win_shape    <= 1'b0;
      bandwidth_hz <= 17'h0;
    end else begin
      blk_lines    <= next_blk_lines;
      win_shape    <= next_win_shape;
      bandwidth_hz <= next_bandwidth;
    end
  end

  // ---- variable-length decoder (order-0 exp-Golomb) ----
  typedef enum logic [1:0] {VLC_PREFIX = 2'b01, VLC_SUFFIX = 2'b10} aesm_vlc_state_t;
  aesm_vlc_state_t vstate;
  aesm_vlc_state_t next_vstate;
  logic [3:0]  zeros;
  logic [3:0]  next_zeros;
  logic [3:0]  left;
  logic [3:0]  next_left;
  logic [15:0] acc;
  logic [15:0] next_acc;
  logic [15:0] code;
  logic        next_vlc_valid;
  logic        next_vlc_err;
  logic [1:0]  next_vlc_kind;
  logic signed [15:0] next_vlc_value;

  always_comb begin
    next_vstate    = vstate;
    next_zeros     = zeros;
    next_left      = left;
    next_acc       = acc;
    next_vlc_valid = 1'b0;
    next_vlc_err   = 1'b0;
    next_vlc_kind  = vlc_kind_out;
    next_vlc_value = vlc_value;
    code           = 16'h0;
    if (bit_valid) begin
      unique case (vstate)
        VLC_PREFIX: begin
          if (!bit_in) begin
            if (zeros == aesm_pkg::VLC_MAX_PREFIX) begin
              next_vlc_err = 1'b1;
              next_zeros   = 4'h0;
            end else
              next_zeros = zeros + 4'h1;
          end else if (zeros == 4'h0) begin
            next_vlc_valid = 1'b1;
            next_vlc_kind  = vlc_kind;
            next_vlc_value = 16'sh0;
          end else begin
            next_vstate = VLC_SUFFIX;
            next_left   = zeros;
            next_acc    = 16'h1;
          end
        end
        VLC_SUFFIX: begin
          next_acc  = {acc[14:0], bit_in};
          next_left = left - 4'h1;
          if (left == 4'h1) begin
            // one code family, signed map for deltas and intensity
            code           = {acc[14:0], bit_in} - 16'h1;
            next_vlc_valid = 1'b1;
            next_vlc_kind  = vlc_kind;
            if (vlc_kind == aesm_pkg::VLC_SPECTRAL)
              next_vlc_value = $signed(code);
            else
              next_vlc_value = code[0] ? $signed({1'b0, code[15:1]} + 16'h1) : -$signed({1'b0, code[15:1]});
            next_vstate = VLC_PREFIX;
            next_zeros  = 4'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      vstate       <= VLC_PREFIX;
      zeros        <= 4'h0;
      left         <= 4'h0;
      acc          <= 16'h0;
      vlc_valid    <= 1'b0;
      vlc_err      <= 1'b0;
      vlc_kind_out <= aesm_pkg::VLC_SPECTRAL;
      vlc_value    <= 16'sh0;
    end else begin
      vstate       <= next_vstate;
      zeros        <= next_zeros;
      left         <= next_left;
      acc          <= next_acc;
      vlc_valid    <= next_vlc_valid;
      vlc_err      <= next_vlc_err;
      vlc_kind_out <= next_vlc_kind;
      vlc_value    <= next_vlc_value;
    end
  end

  // ---- spectral path: inverse quantizer, mid/side, down-mix ----
  function automatic logic signed [31:0] mix(input logic signed [31:0] a, input logic signed [31:0] b,
                                             input logic signed [31:0] c, input logic [7:0] k);
    logic signed [41:0] side_sum;
    side_sum = (42'(b) + 42'(c)) * $signed({1'b0, k});
    return 32'(42'(a) + (side_sum >>> aesm_pkg::COEF_FRAC_BITS));
  endfunction

  logic signed [31:0] iq_first;
  logic signed [31:0] iq_second;
  logic               in_band;
  logic               stage_valid;
  logic               next_stage_valid;
  logic               stage_keep;
  logic               next_stage_keep;
  logic signed [31:0] rec_l;
  logic signed [31:0] rec_r;
  logic signed [31:0] next_left_out;
  logic signed [31:0] next_right_out;

  aesm_inv_quant u_iq_first (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .q_in    (spec_in.first),
    .sf      (spec_in.sf),
    .value   (iq_first)
  );

  aesm_inv_quant u_iq_second (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .q_in    (spec_in.second),
    .sf      (spec_in.sf),
    .value   (iq_second)
  );

  always_comb begin
    in_band          = band_scalable_profile[spec_in.band];
    next_stage_valid = spec_valid;
    next_stage_keep  = in_band;
    // left = mid + side, right = mid - side; off passes through
    rec_l = ms_en ? iq_first + iq_second : iq_first;
    rec_r = ms_en ? iq_first - iq_second : iq_second;
    // down-mix with user coefficient; off passes through
    if (dmx_en) begin
      next_left_out  = mix(rec_l, spec_dmx.centre, spec_dmx.surr_l, dmx_coef);
      next_right_out = mix(rec_r, spec_dmx.centre, spec_dmx.surr_r, dmx_coef);
    end else begin
      next_left_out  = rec_l;
      next_right_out = rec_r;
    end
    // mute on error or dropped band
    if (!stage_valid || cfg_err || !stage_keep) begin
      next_left_out  = 32'sh0;
      next_right_out = 32'sh0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stage_valid <= 1'b0;
      stage_keep  <= 1'b0;
      out_valid   <= 1'b0;
      out_left    <= 32'sh0;
      out_right   <= 32'sh0;
    end else begin
      stage_valid <= next_stage_valid;
      stage_keep  <= next_stage_keep;
      out_valid   <= stage_valid;
      out_left    <= next_left_out;
      out_right   <= next_right_out;
    end
  end
endmodule
`default_nettype wire

// File: bench/aesm_top_checker.sv
/*
  Concurrent checks on the ports of aesm_top.
  Assumes it is bound into aesm_top and that aesm_pkg is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module aesm_top_checker (
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  input wire logic                 cfg_valid,
  input wire logic          [16:0] cfg_rate_hz,
  input wire logic          [2:0]  cfg_layout,
  input wire logic          [5:0]  cfg_channels,
  input wire logic                 elem_valid,
  input wire logic          [1:0]  elem_kind,
  input wire aesm_pkg::aesm_map_t  map_out,
  input wire logic                 map_valid,
  input wire logic                 blk_valid,
  input wire logic                 blk_short,
  input wire logic                 blk_win_shape,
  input wire logic          [10:0] blk_lines,
  input wire logic                 win_shape,
  input wire logic          [3:0]  band_scalable_profile,
  input wire logic          [16:0] bandwidth_hz,
  input wire logic                 spec_valid,
  input wire aesm_pkg::aesm_spec_t spec_in,
  input wire logic                 out_valid,
  input wire logic signed   [31:0] out_left,
  input wire logic signed   [31:0] out_right,
  input wire logic                 cfg_err
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_mono_cfg;
    cfg_valid && cfg_layout == aesm_pkg::LAY_1;
  endsequence
  sequence s_mono_elem;
    elem_valid && !cfg_valid && elem_kind == aesm_pkg::EL_SINGLE;
  endsequence
  sequence s_spec_err;
    spec_valid ##1 cfg_err;
  endsequence
  sequence s_band_off;
    spec_valid ##1 !band_scalable_profile[$past(spec_in.band)];
  endsequence

  a_bad_layout: assert property (cfg_valid && cfg_layout == 3'h0 |=> cfg_err)
    else $error("illegal layout not flagged");
  a_chan_limit: assert property (cfg_valid && cfg_channels > aesm_pkg::MAX_CHANNELS |=> cfg_err)
    else $error("too many channels not flagged");
  a_err_sticky: assert property (cfg_err && !cfg_valid |=> cfg_err)
    else $error("error flag dropped without new config");
  a_map_pulse: assert property (!elem_valid || cfg_valid |=> !map_valid)
    else $error("map valid without an element");
  a_mono_centre: assert property (s_mono_cfg ##1 s_mono_elem |=> map_valid && map_out.spk0 == aesm_pkg::SPK_CF
    && map_out.last)
    else $error("mono element not on centre front");
  a_blk_lines: assert property (blk_valid |=> blk_lines == ($past(blk_short) ? 11'h080 : 11'h400))
    else $error("block length wrong");
  a_win_follow: assert property (blk_valid |=> win_shape == $past(blk_win_shape))
    else $error("window shape not applied");
  a_bw_lowest: assert property (cfg_valid && cfg_rate_hz == 17'h0bb80 ##1 band_scalable_profile == 4'h1
    && !cfg_valid |=> bandwidth_hz == 17'h01770)
    else $error("lowest band bandwidth wrong");
  a_mute_out: assert property (s_spec_err |=> out_valid && out_left == '0 && out_right == '0)
    else $error("output not muted on error");
  a_band_off: assert property (s_band_off |=> out_left == '0 && out_right == '0)
    else $error("unselected band reached output");
  a_spec_lat: assert property (spec_valid |-> ##2 out_valid)
    else $error("spectral output missing");
endmodule
`default_nettype wire

// File: bench/aesm_bit_src.sv
/*
  Behavioural model of the stream parser feeding variable-length codes.
  Assumes one clock; a gap of idle cycles between bits models a slow parser.
*/
`timescale 1ns/1ps
`default_nettype none
module aesm_bit_src (
  input  wire logic       clk_sys,
  output logic            bit_valid,
  output logic            bit_in,
  output logic      [1:0] vlc_kind
);
  initial begin
    bit_valid = 1'b0;
    bit_in = 1'b0;
    vlc_kind = 2'h0;
  end
  task automatic send(input logic [1:0] kind, input int v, input int gap);
    logic [16:0] x;
    int          n;
    x = (kind == aesm_pkg::VLC_SPECTRAL) ? 17'(v + 1) : ((v > 0) ? 17'(2 * v) : 17'(1 - 2 * v));
    n = $clog2(x + 1) - 1;
    vlc_kind = kind;
    for (int i = 0; i < 2 * n + 1; i++) begin
      // idle line toggles so a stale bit is never mistaken for data
      if (i > 0) begin
        repeat (gap) begin
          bit_valid = 1'b0;
          bit_in = ~bit_in;
          @(posedge clk_sys);
          #1;
        end
      end
      bit_valid = 1'b1;
      bit_in = (i < n) ? 1'b0 : x[2 * n - i];
      @(posedge clk_sys);
      #1;
    end
    bit_valid = 1'b0;
    bit_in = ~bit_in;
  endtask
endmodule
`default_nettype wire

// File: bench/aesm_top_tb.sv
/*
  Self-checking bench for aesm_top with a parser model and bound checker.
  Assumes a 50 MHz clock; inputs change 1 ns after each rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module aesm_top_tb;
  logic                 clk_sys = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 cfg_valid = 1'b0, elem_valid = 1'b0, blk_valid = 1'b0, spec_valid = 1'b0;
  logic          [16:0] cfg_rate_hz = 17'h0bb80;
  logic          [2:0]  cfg_layout = 3'h2;
  logic          [5:0]  cfg_channels = 6'h02;
  logic          [1:0]  elem_kind = 2'h0, vlc_kind, vlc_kind_out, k;
  logic                 blk_short = 1'b0, blk_win_shape = 1'b0, ms_en = 1'b0, dmx_en = 1'b0;
  logic          [3:0]  band_scalable_profile = 4'hf;
  logic          [7:0]  dmx_coef = 8'h00;
  aesm_pkg::aesm_spec_t spec_in = '0;
  aesm_pkg::aesm_dmx_t  spec_dmx = '0;
  aesm_pkg::aesm_map_t  map_out, m;
  logic                 map_valid, win_shape, bit_valid, bit_in, vlc_valid, vlc_err, out_valid, cfg_err;
  logic          [10:0] blk_lines;
  logic          [16:0] bandwidth_hz, rr;
  logic signed   [15:0] vlc_value;
  logic signed   [31:0] out_left, out_right;
  int                   n_mismatch = 0, check_count = 0, v, a, b, l, r;

  always #10 clk_sys = ~clk_sys;

  aesm_top dut (.clk_sys, .sys_rst, .cfg_valid, .cfg_rate_hz, .cfg_layout, .cfg_channels, .elem_valid,
    .elem_kind, .map_out, .map_valid, .blk_valid, .blk_short, .blk_win_shape, .blk_lines, .win_shape,
    .band_scalable_profile, .bandwidth_hz, .bit_valid, .bit_in, .vlc_kind, .vlc_valid, .vlc_kind_out,
    .vlc_value, .vlc_err, .spec_valid, .spec_in, .spec_dmx, .ms_en, .dmx_en, .dmx_coef, .out_valid,
    .out_left, .out_right, .cfg_err);
  aesm_bit_src src (.clk_sys, .bit_valid, .bit_in, .vlc_kind);

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic set_cfg(input logic [16:0] rt, input logic [2:0] ly, input logic [5:0] ch);
    cfg_valid = 1'b1;
    cfg_rate_hz = rt;
    cfg_layout = ly;
    cfg_channels = ch;
    tick();
    cfg_valid = 1'b0;
  endtask

  function automatic logic rate_ok(input logic [16:0] rt);
    for (int i = 0; i < 12; i++) if (rt == aesm_pkg::RATE_TABLE[i]) return 1'b1;
    return 1'b0;
  endfunction

  // element i of a layout; kind 3 marks the end of the sequence
  function automatic aesm_pkg::aesm_map_t exp_map(input int ly, input int i);
    logic [23:0]         t;
    logic [7:0]          sp [7] = '{8'h10, 8'h23, 8'h80, 8'h9a, 8'hb0, 8'h45, 8'h67};
    aesm_pkg::aesm_map_t e;
    case (ly)
      1: t = 24'h0fffff;
      2: t = 24'h1fffff;
      3: t = 24'h01ffff;
      4: t = 24'h012fff;
      5: t = 24'h013fff;
      6: t = 24'h0134ff;
      default: t = 24'h05634f;
    endcase
    t = t << (4 * i);
    e.kind = (t[23:20] == 4'h4) ? aesm_pkg::EL_LFE : (t[23:20] inside {4'h0, 4'h2}) ? aesm_pkg::EL_SINGLE : aesm_pkg::EL_PAIR;
    if (t[23:20] > 4'h6) e.kind = 2'h3;
    else {e.spk0, e.spk1} = sp[t[23:20]];
    e.last = (t[19:16] == 4'hf);
    return e;
  endfunction

  function automatic int iq(input logic signed [15:0] q, input logic [5:0] sf);
    int     mg;
    longint x;
    mg = (q < 0) ? -int'(q) : int'(q);
    if (mg > 15) mg = 15;
    x = ((longint'(aesm_pkg::IQ_POW_TABLE[mg]) * aesm_pkg::IQ_GAIN_TABLE[sf[1:0]]) << sf[5:2]) >> 12;
    return (q < 0) ? -int'(x) : int'(x);
  endfunction

  initial begin
    repeat (10000) @(posedge clk_sys);
    n_mismatch++;
    finish_test();
  end

  initial begin
    void'($urandom(28));
    repeat (16) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    check(cfg_err, 1'b1);
    check(blk_lines, 11'h400);
    check({map_valid, out_valid, vlc_valid}, 3'h0);
    $display("reset done");
    for (int i = 0; i < 12; i++) begin
      set_cfg(aesm_pkg::RATE_TABLE[i], aesm_pkg::LAY_2, 6'h02);
      check(cfg_err, 1'b0);
      rr = (i < 3) ? aesm_pkg::RATE_TABLE[i] + 17'h1 : 17'($urandom);
      set_cfg(rr, aesm_pkg::LAY_2, 6'h02);
      check(cfg_err, !rate_ok(rr));
    end
    set_cfg(17'h0bb80, aesm_pkg::LAY_2, 6'h30);
    check(cfg_err, 1'b0);
    set_cfg(17'h0bb80, aesm_pkg::LAY_2, 6'h31);
    check(cfg_err, 1'b1);
    set_cfg(17'h0bb80, aesm_pkg::LAY_2, 6'h00);
    check(cfg_err, 1'b1);
    set_cfg(17'h0bb80, 3'h0, 6'h02);
    check(cfg_err, 1'b1);
    $display("config done");
    for (int ly = 1; ly < 8; ly++) begin
      set_cfg(17'h0bb80, 3'(ly), 6'h08);
      for (int i = 0; i < 6; i++) begin
        m = exp_map(ly, i);
        elem_valid = 1'b1;
        elem_kind = (m.kind == 2'h3) ? aesm_pkg::EL_SINGLE : m.kind;
        tick();
        if (m.kind == 2'h3) begin
          check(map_out.spk0, aesm_pkg::SPK_NONE);
          check(cfg_err, 1'b1);
          break;
        end
        check(map_valid, 1'b1);
        check(map_out, m);
      end
      elem_valid = 1'b0;
    end
    $display("mapping done");
    repeat (12) begin
      blk_valid = 1'b1;
      blk_short = 1'($urandom);
      blk_win_shape = 1'($urandom);
      tick();
      check(blk_lines, blk_short ? 11'h080 : 11'h400);
      check(win_shape, blk_win_shape);
    end
    blk_valid = 1'b0;
    $display("block done");
    for (int i = 1; i < 24; i++) begin
      rr = (i < 16) ? 17'h0bb80 : aesm_pkg::RATE_TABLE[$urandom_range(0, 11)];
      set_cfg(rr, aesm_pkg::LAY_2, 6'h02);
      band_scalable_profile = (i < 16) ? 4'(i) : 4'($urandom_range(1, 15));
      tick();
      tick();
      check(bandwidth_hz, 17'((rr >> 3) * $clog2(band_scalable_profile + 5'h01)));
    end
    $display("band done");
    for (int i = 0; i < 24; i++) begin
      k = 2'(i % 3);
      v = (k == aesm_pkg::VLC_SPECTRAL) ? int'($urandom_range(0, 300)) : int'($urandom_range(0, 200)) - 100;
      if (i < 3) v = 0;
      src.send(k, v, i % 4);
      check({vlc_valid, vlc_err}, 2'h2);
      check(vlc_kind_out, k);
      check(vlc_value, 16'(v));
    end
    $display("code done");
    set_cfg(17'h0bb80, aesm_pkg::LAY_2, 6'h02);
    for (int i = 0; i < 30; i++) begin
      if (i == 25) set_cfg(17'h0bb80, 3'h0, 6'h02);
      spec_in.first = 16'(int'($urandom_range(0, 60)) - 30);
      spec_in.second = 16'(int'($urandom_range(0, 60)) - 30);
      spec_in.sf = 6'($urandom);
      spec_in.band = 2'($urandom);
      {dmx_en, ms_en} = 2'(i % 5);
      dmx_coef = 8'($urandom);
      spec_dmx.centre = int'($urandom_range(0, 2000)) - 1000;
      spec_dmx.surr_l = int'($urandom_range(0, 2000)) - 1000;
      spec_dmx.surr_r = int'($urandom_range(0, 2000)) - 1000;
      band_scalable_profile = 4'($urandom_range(1, 15));
      band_scalable_profile[spec_in.band] = (i % 5 != 4);
      spec_valid = 1'b1;
      tick();
      spec_valid = 1'b0;
      tick();
      a = iq(spec_in.first, spec_in.sf);
      b = iq(spec_in.second, spec_in.sf);
      l = ms_en ? a + b : a;
      r = ms_en ? a - b : b;
      if (dmx_en) begin
        l += ((spec_dmx.centre + spec_dmx.surr_l) * int'(dmx_coef)) >>> 8;
        r += ((spec_dmx.centre + spec_dmx.surr_r) * int'(dmx_coef)) >>> 8;
      end
      if (cfg_err || !band_scalable_profile[spec_in.band]) {l, r} = 64'h0;
      check(out_valid, 1'b1);
      check(out_left, l);
      check(out_right, r);
    end
    $display("spectral done");
    finish_test();
  end
endmodule

bind aesm_top aesm_top_checker u_chk (.clk_sys, .sys_rst, .cfg_valid, .cfg_rate_hz, .cfg_layout, .cfg_channels,
  .elem_valid, .elem_kind, .map_out, .map_valid, .blk_valid, .blk_short, .blk_win_shape, .blk_lines, .win_shape,
  .band_scalable_profile, .bandwidth_hz, .spec_valid, .spec_in, .out_valid, .out_left, .out_right, .cfg_err);
`default_nettype wire
